/* File: rtl/dsp_top.sv */
`timescale 1ns/10ps
module dsp_top #(
  parameter int PM_BYTES = dsp_pkg::PM_BYTES_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic debug_serial_pin_in,
  output logic debug_serial_pin_out,
  output logic debug_serial_pin_oe,
  input wire dsp_pkg::dsp_rst_src_t rst_src,
  input wire logic stop_mode,
  input wire logic small_package,
  input wire logic read_protect,
  input wire logic ctl_wr,
  input wire dsp_pkg::dsp_ctl_t ctl_wdata,
  output logic debug_mode_enable,
  output logic breakpoint_instruction_en,
  output logic sys_reset_req,
  output logic [dsp_pkg::PM_AW-1:0] pm_addr,
  input wire logic [7:0] pm_data,
  output logic crc_busy,
  output logic step_req,
  output logic stuff_req,
  output logic [7:0] stuff_opcode,
  output logic [7:0] exec_opcode,
  input wire logic [2:0] exec_len,
  output logic exec_valid,
  input wire logic exec_ready,
  output logic [7:0] exec_data
);

  logic rst_s1_r;
  logic rst_s2_r;
  logic rst_i_n;
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin;
  logic rst_any;
  logic allowed;

  dsp_pkg::dsp_rx_st_t rx_st_r;
  logic [dsp_pkg::BIT_W-1:0] bit_r;
  logic [dsp_pkg::BIT_W-1:0] rx_cnt_r;
  logic [dsp_pkg::CAL_W-1:0] cal_cnt_r;
  logic [dsp_pkg::CAL_W-1:0] cal_bit;
  logic [2:0] rx_nbit_r;
  logic [7:0] rx_sh_r;
  logic [7:0] rx_byte_r;
  logic rx_v_r;
  logic cal_done_r;

  logic tx_busy_r;
  logic [9:0] tx_sh_r;
  logic [dsp_pkg::BIT_W-1:0] tx_cnt_r;
  logic [3:0] tx_left_r;
  logic [7:0] txq_hi_r;
  logic [7:0] txq_lo_r;
  logic [1:0] txq_cnt_r;

  dsp_pkg::dsp_cmd_st_t cmd_st_r;
  logic [2:0] remain_r;
  logic reply_v_r;
  logic [15:0] reply_r;
  logic crc_start_r;
  logic crc_done;
  logic [15:0] crc_val;
  logic push_v_r;
  logic [7:0] push_d_r;
  logic buf_in_ready;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_i_n = rst_s2_r;

  // pin comes from the host, so synchronise before use
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end else begin
      pin_s1_r <= debug_serial_pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end
  assign pin = pin_s2_r;

  assign rst_any = rst_src.por | rst_src.bor | rst_src.wdt | rst_src.ext;
  assign allowed = debug_mode_enable & ~read_protect;
  assign cal_bit = cal_cnt_r >> dsp_pkg::CAL_SHIFT;

  // receiver: calibrate after each reset, then frame characters
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      rx_st_r <= dsp_pkg::RX_CAL_HI;
      bit_r <= dsp_pkg::BIT_RST;
      rx_cnt_r <= '0;
      cal_cnt_r <= '0;
      rx_nbit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_byte_r <= 8'h00;
      rx_v_r <= 1'b0;
      cal_done_r <= 1'b0;
    end else begin
      rx_v_r <= 1'b0;
      cal_done_r <= 1'b0;
      if (rst_any) begin
        rx_st_r <= dsp_pkg::RX_CAL_HI;
      end else begin
        case (rx_st_r)
          dsp_pkg::RX_CAL_HI: begin
            if (pin) rx_st_r <= dsp_pkg::RX_CAL_ARM;
          end
          dsp_pkg::RX_CAL_ARM: begin
            if (!pin) begin
              cal_cnt_r <= dsp_pkg::CAL_ONE;
              rx_st_r <= dsp_pkg::RX_CAL_LOW;
            end
          end
          dsp_pkg::RX_CAL_LOW: begin
            // low run of start plus seven zeros is eight bit times
            if (!pin) begin
              if (cal_cnt_r != dsp_pkg::CAL_MAX) cal_cnt_r <= cal_cnt_r + dsp_pkg::CAL_ONE;
            end else begin
              if (cal_bit[dsp_pkg::BIT_W-1:0] < dsp_pkg::BIT_MIN) bit_r <= dsp_pkg::BIT_MIN;
              else bit_r <= cal_bit[dsp_pkg::BIT_W-1:0];
              cal_done_r <= 1'b1;
              rx_st_r <= dsp_pkg::RX_IDLE;
            end
          end
          dsp_pkg::RX_IDLE: begin
            // own transmission is not heard back
            if (!tx_busy_r && !pin) begin
              rx_cnt_r <= bit_r >> 1;
              rx_st_r <= dsp_pkg::RX_START;
            end
          end
          dsp_pkg::RX_START: begin
            if (rx_cnt_r != '0) begin
              rx_cnt_r <= rx_cnt_r - dsp_pkg::BIT_ONE;
            end else if (!pin) begin
              rx_cnt_r <= bit_r - dsp_pkg::BIT_ONE;
              rx_nbit_r <= 3'h0;
              rx_st_r <= dsp_pkg::RX_DATA;
            end else begin
              rx_st_r <= dsp_pkg::RX_IDLE; // glitch, not a start bit
            end
          end
          dsp_pkg::RX_DATA: begin
            if (rx_cnt_r != '0) begin
              rx_cnt_r <= rx_cnt_r - dsp_pkg::BIT_ONE;
            end else begin
              rx_sh_r <= {pin, rx_sh_r[7:1]};
              rx_cnt_r <= bit_r - dsp_pkg::BIT_ONE;
              if (rx_nbit_r == dsp_pkg::LAST_DATA_BIT) rx_st_r <= dsp_pkg::RX_STOP;
              else rx_nbit_r <= rx_nbit_r + 3'h1;
            end
          end
          dsp_pkg::RX_STOP: begin
            if (rx_cnt_r != '0) begin
              rx_cnt_r <= rx_cnt_r - dsp_pkg::BIT_ONE;
            end else begin
              // a low stop bit is a framing error and is dropped
              if (pin) begin
                rx_byte_r <= rx_sh_r;
                rx_v_r <= 1'b1;
              end
              rx_st_r <= dsp_pkg::RX_IDLE;
            end
          end
          default: rx_st_r <= dsp_pkg::RX_CAL_HI;
        endcase
      end
    end
  end

  // transmitter and its two-byte reply queue
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      tx_busy_r <= 1'b0;
      tx_sh_r <= 10'h3FF;
      tx_cnt_r <= '0;
      tx_left_r <= 4'h0;
      txq_hi_r <= 8'h00;
      txq_lo_r <= 8'h00;
      txq_cnt_r <= 2'h0;
    end else if (rst_any) begin
      tx_busy_r <= 1'b0;
      tx_sh_r <= 10'h3FF;
      txq_cnt_r <= 2'h0;
    end else begin
      if (reply_v_r) begin
        txq_hi_r <= reply_r[15:8];
        txq_lo_r <= reply_r[7:0];
        txq_cnt_r <= 2'h2;
      end else if (!tx_busy_r && txq_cnt_r != 2'h0) begin
        // start at once, even right after a stop sample
        tx_sh_r <= {1'b1, txq_hi_r, 1'b0};
        tx_busy_r <= 1'b1;
        tx_cnt_r <= bit_r - dsp_pkg::BIT_ONE;
        tx_left_r <= dsp_pkg::FRAME_LAST;
        txq_hi_r <= txq_lo_r;
        txq_cnt_r <= txq_cnt_r - 2'h1;
      end
      if (tx_busy_r) begin
        if (tx_cnt_r != '0) begin
          tx_cnt_r <= tx_cnt_r - dsp_pkg::BIT_ONE;
        end else if (tx_left_r == 4'h0) begin
          tx_busy_r <= 1'b0;
          tx_sh_r <= 10'h3FF;
        end else begin
          tx_sh_r <= {1'b1, tx_sh_r[9:1]};
          tx_left_r <= tx_left_r - 4'h1;
          tx_cnt_r <= bit_r - dsp_pkg::BIT_ONE;
        end
      end
    end
  end

  // drive only while a frame is going out
  assign debug_serial_pin_oe = tx_busy_r;
  assign debug_serial_pin_out = tx_sh_r[0];

  // command decoder
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      cmd_st_r <= dsp_pkg::C_IDLE;
      remain_r <= 3'h0;
      reply_v_r <= 1'b0;
      reply_r <= 16'h0000;
      crc_start_r <= 1'b0;
      step_req <= 1'b0;
      stuff_req <= 1'b0;
      stuff_opcode <= 8'h00;
      exec_opcode <= 8'h00;
    end else begin
      reply_v_r <= 1'b0;
      crc_start_r <= 1'b0;
      step_req <= 1'b0;
      stuff_req <= 1'b0;
      if (rst_any) begin
        cmd_st_r <= dsp_pkg::C_IDLE;
      end else begin
        case (cmd_st_r)
          dsp_pkg::C_IDLE: begin
            if (rx_v_r) begin
              case (rx_byte_r)
                dsp_pkg::CMD_CRC: begin
                  if (debug_mode_enable) begin
                    crc_start_r <= 1'b1;
                    cmd_st_r <= dsp_pkg::C_CRC;
                  end else begin
                    reply_r <= dsp_pkg::CRC_NODBG;
                    reply_v_r <= 1'b1;
                  end
                end
                dsp_pkg::CMD_STEP: step_req <= allowed;
                dsp_pkg::CMD_STUFF: cmd_st_r <= dsp_pkg::C_STUFF_OP;
                dsp_pkg::CMD_EXEC: begin
                  if (allowed) cmd_st_r <= dsp_pkg::C_EXEC_FIRST;
                  else cmd_st_r <= dsp_pkg::C_DISCARD;
                end
                default: cmd_st_r <= dsp_pkg::C_IDLE;
              endcase
            end
          end
          dsp_pkg::C_CRC: begin
            // host has to wait out the whole memory scan
            if (crc_done) begin
              reply_r <= crc_val;
              reply_v_r <= 1'b1;
              cmd_st_r <= dsp_pkg::C_IDLE;
            end
          end
          dsp_pkg::C_STUFF_OP: begin
            if (rx_v_r) begin
              stuff_opcode <= rx_byte_r;
              stuff_req <= allowed;
              cmd_st_r <= dsp_pkg::C_IDLE;
            end
          end
          dsp_pkg::C_EXEC_FIRST: begin
            if (rx_v_r) begin
              exec_opcode <= rx_byte_r;
              cmd_st_r <= dsp_pkg::C_EXEC_LEN;
            end
          end
          dsp_pkg::C_EXEC_LEN: begin
            // length comes from the cpu decoder looking at exec_opcode
            remain_r <= exec_len - 3'h1;
            if (exec_len <= 3'h1) cmd_st_r <= dsp_pkg::C_IDLE;
            else cmd_st_r <= dsp_pkg::C_EXEC_REST;
          end
          dsp_pkg::C_EXEC_REST: begin
            if (rx_v_r) begin
              remain_r <= remain_r - 3'h1;
              if (remain_r == 3'h1) cmd_st_r <= dsp_pkg::C_IDLE;
            end
          end
          dsp_pkg::C_DISCARD: begin
            if (rx_v_r) cmd_st_r <= dsp_pkg::C_IDLE;
          end
          default: cmd_st_r <= dsp_pkg::C_IDLE;
        endcase
      end
    end
  end

  // instruction bytes head for the cpu; a word arriving while one waits overwrites it, so the waiting one is lost
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      push_v_r <= 1'b0;
      push_d_r <= 8'h00;
    end else if (rst_any) begin
      push_v_r <= 1'b0;
    end else if (rx_v_r && (cmd_st_r == dsp_pkg::C_EXEC_FIRST || cmd_st_r == dsp_pkg::C_EXEC_REST)) begin
      push_v_r <= 1'b1;
      push_d_r <= rx_byte_r;
    end else if (buf_in_ready) begin
      push_v_r <= 1'b0;
    end
  end

  // mode and breakpoint enable, resets win over software
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      debug_mode_enable <= dsp_pkg::DBG_MODE_RST;
      breakpoint_instruction_en <= dsp_pkg::BRK_EN_RST;
    end else if (rst_any) begin
      debug_mode_enable <= dsp_pkg::DBG_MODE_RST;
      breakpoint_instruction_en <= dsp_pkg::BRK_EN_RST;
    end else if (ctl_wr) begin
      debug_mode_enable <= ctl_wdata.mode;
      breakpoint_instruction_en <= ctl_wdata.breakpoint_instruction;
    end else if (cal_done_r && small_package) begin
      debug_mode_enable <= 1'b1;
    end
  end

  // system reset request from stop-mode wake or software
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      sys_reset_req <= 1'b0;
    end else begin
      sys_reset_req <= (stop_mode & ~pin) | (ctl_wr & ctl_wdata.reset);
    end
  end

  dsp_crc #(
    .N_BYTES(PM_BYTES)
  ) u_crc (
    .clk(sys_clk),
    .rst_n(rst_i_n),
    .start(crc_start_r),
    .pm_data(pm_data),
    .pm_addr(pm_addr),
    .busy(crc_busy),
    .done(crc_done),
    .crc(crc_val)
  );

  dsp_buf2 #(
    .W(8)
  ) u_buf (
    .clk(sys_clk),
    .rst_n(rst_i_n),
    .flush(rst_any),
    .in_valid(push_v_r),
    .in_ready(buf_in_ready),
    .in_data(push_d_r),
    .out_valid(exec_valid),
    .out_ready(exec_ready),
    .out_data(exec_data)
  );

endmodule

/* File: rtl/dsp_pkg.sv */
package dsp_pkg;

  // host command bytes
  localparam logic [7:0] CMD_CRC = 8'h0E;
  localparam logic [7:0] CMD_STEP = 8'h10;
  localparam logic [7:0] CMD_STUFF = 8'h11;
  localparam logic [7:0] CMD_EXEC = 8'h12;

  // character framing and baud measurement
  localparam int BIT_W = 10;
  localparam int CAL_W = 13;
  localparam int CAL_SHIFT = 3;
  localparam logic [BIT_W-1:0] BIT_ONE = 10'h001;
  localparam logic [BIT_W-1:0] BIT_MIN = 10'h002;
  localparam logic [BIT_W-1:0] BIT_RST = 10'h010;
  localparam logic [CAL_W-1:0] CAL_ONE = 13'h0001;
  localparam logic [CAL_W-1:0] CAL_MAX = 13'h1FFF;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  localparam logic [3:0] FRAME_LAST = 4'h9;

  // program memory and crc
  localparam int PM_AW = 13;
  localparam int PM_BYTES_DEF = 8192;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_NODBG = 16'hFFFF;

  // values after reset
  localparam logic DBG_MODE_RST = 1'b0;
  localparam logic BRK_EN_RST = 1'b0;

  typedef struct packed {
    logic mode;
    logic breakpoint_instruction;
    logic reset;
  } dsp_ctl_t;

  typedef struct packed {
    logic por;
    logic bor;
    logic wdt;
    logic ext;
  } dsp_rst_src_t;

  typedef enum logic [2:0] {
    RX_CAL_HI = 3'h0,
    RX_CAL_ARM = 3'h1,
    RX_CAL_LOW = 3'h2,
    RX_IDLE = 3'h3,
    RX_START = 3'h4,
    RX_DATA = 3'h5,
    RX_STOP = 3'h6
  } dsp_rx_st_t;

  typedef enum logic [2:0] {
    C_IDLE = 3'h0,
    C_STUFF_OP = 3'h1,
    C_EXEC_FIRST = 3'h2,
    C_EXEC_LEN = 3'h3,
    C_EXEC_REST = 3'h4,
    C_DISCARD = 3'h5,
    C_CRC = 3'h6
  } dsp_cmd_st_t;

  // one byte into a crc-ccitt, msb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

endpackage

/* File: rtl/dsp_buf2.sv */
`timescale 1ns/10ps
module dsp_buf2 #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] mem_r [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  // two entries so one stalled word does not block the next
  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end else if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else if (flush) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop) rp_r <= ~rp_r;
      if (push && !pop) cnt_r <= cnt_r + 2'h1;
      else if (pop && !push) cnt_r <= cnt_r - 2'h1;
    end
  end

endmodule

/* File: rtl/dsp_crc.sv */
`timescale 1ns/10ps
module dsp_crc #(
  parameter int N_BYTES = dsp_pkg::PM_BYTES_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] pm_data,
  output logic [dsp_pkg::PM_AW-1:0] pm_addr,
  output logic busy,
  output logic done,
  output logic [15:0] crc
);

  localparam logic [dsp_pkg::PM_AW-1:0] LAST = dsp_pkg::PM_AW'(N_BYTES - 1);

  logic issue_r;
  logic dv_r;
  logic dlast_r;

  // one byte a cycle; memory answers one cycle after the address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pm_addr <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      crc <= dsp_pkg::CRC_INIT;
      issue_r <= 1'b0;
      dv_r <= 1'b0;
      dlast_r <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        pm_addr <= '0;
        busy <= 1'b1;
        crc <= dsp_pkg::CRC_INIT;
        issue_r <= 1'b1;
        dv_r <= 1'b0;
        dlast_r <= 1'b0;
      end else if (busy) begin
        dv_r <= issue_r;
        dlast_r <= issue_r && (pm_addr == LAST);
        if (issue_r) begin
          if (pm_addr == LAST) issue_r <= 1'b0;
          else pm_addr <= pm_addr + 1'b1;
        end
        if (dv_r) crc <= dsp_pkg::crc_byte(crc, pm_data);
        if (dlast_r) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule

/* File: bench/dsp_top_assertions.sv */
`timescale 1ns/10ps
module dsp_chk #(
  parameter int PM_BYTES = 16
) (
  input logic sys_clk,
  input logic rst_n,
  input logic debug_serial_pin_in,
  input logic debug_serial_pin_out,
  input logic debug_serial_pin_oe,
  input dsp_pkg::dsp_rst_src_t rst_src,
  input logic stop_mode,
  input logic read_protect,
  input logic ctl_wr,
  input dsp_pkg::dsp_ctl_t ctl_wdata,
  input logic debug_mode_enable,
  input logic breakpoint_instruction_en,
  input logic sys_reset_req,
  input logic crc_busy,
  input logic step_req,
  input logic stuff_req,
  input logic [7:0] stuff_opcode,
  input logic exec_valid,
  input logic exec_ready,
  input logic [7:0] exec_data
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] age_r;
  logic heard_r;
  logic [15:0] busy_r;
  dsp_pkg::dsp_ctl_t wd_r;
  logic live;
  // internal reset lags the pin by two edges, so skip the first three
  assign live = (age_r == 2'h3);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) age_r <= 2'h0;
    else if (!live) age_r <= age_r + 2'h1;
  end
  // any low on the line since the last reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) heard_r <= 1'b0;
    else if (|rst_src) heard_r <= 1'b0;
    else if (!debug_serial_pin_in) heard_r <= 1'b1;
  end
  // length of the current crc scan, and ctl_wdata from one cycle before
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) busy_r <= 16'h0000;
    else busy_r <= crc_busy ? busy_r + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge sys_clk) wd_r <= ctl_wdata;

  property p_start_low; $rose(debug_serial_pin_oe) |-> !debug_serial_pin_out; endproperty
  a_start_low: assert property (p_start_low) else $error("frame opened without low start bit");
  property p_stop_high; $fell(debug_serial_pin_oe) |-> $past(debug_serial_pin_out); endproperty
  a_stop_high: assert property (p_stop_high) else $error("frame closed without high stop bit");
  property p_quiet; debug_serial_pin_oe |-> heard_r; endproperty
  a_quiet: assert property (p_quiet) else $error("port spoke before any host character");
  property p_src_clear; live && (|rst_src) |=> !debug_mode_enable && !breakpoint_instruction_en; endproperty
  a_src_clear: assert property (p_src_clear) else $error("reset source left debug mode set");
  property p_ctl; live && ctl_wr && !(|rst_src) |=> debug_mode_enable == wd_r.mode && breakpoint_instruction_en == wd_r.breakpoint_instruction;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control write not applied");
  property p_sw_rst; live && ctl_wr && ctl_wdata.reset && !(|rst_src) |=> sys_reset_req; endproperty
  a_sw_rst: assert property (p_sw_rst) else $error("control reset bit gave no reset request");
  property p_stop_wake; (live && stop_mode && !debug_serial_pin_in)[*4] |-> sys_reset_req; endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("low line in stop mode gave no reset");
  property p_step; step_req |-> ($past(debug_mode_enable) && !$past(read_protect)) ##1 !step_req; endproperty
  a_step: assert property (p_step) else $error("step pulse not allowed or too long");
  property p_stuff; stuff_req |-> ($past(debug_mode_enable) && !$past(read_protect)) ##1 $stable(stuff_opcode);
  endproperty
  a_stuff: assert property (p_stuff) else $error("stuff pulse not allowed or opcode moved");
  property p_crc_dbg; $rose(crc_busy) |-> debug_mode_enable; endproperty
  a_crc_dbg: assert property (p_crc_dbg) else $error("crc scan outside debug mode");
  property p_crc_len; crc_busy |-> busy_r < 16'(PM_BYTES + 8); endproperty
  a_crc_len: assert property (p_crc_len) else $error("crc scan longer than memory size");
  property p_buf_hold; exec_valid && !exec_ready |=> exec_valid && $stable(exec_data); endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("stalled instruction byte lost");
  c_crc: cover property ($rose(crc_busy));
  c_exec: cover property (exec_valid && exec_ready);
  c_stuff: cover property (stuff_req);
endmodule

/* File: bench/dsp_host.sv */
`timescale 1ns/10ps
module dsp_host #(
  parameter int BT = 16
) (
  input logic clk,
  input logic line,
  output logic host_low
);
  initial host_low = 1'b0;
  // open drain only: the high level always comes from the pull-up
  task automatic send_byte(input logic [7:0] v);
    logic [9:0] fr;
    fr = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      host_low = !fr[i];
      repeat (BT - 1) @(negedge clk);
    end
  endtask
  // bounded wait for a start bit, then mid-bit sampling
  task automatic recv_byte(input int limit, output logic [7:0] v, output logic ok);
    int n;
    n = 0;
    v = 8'h00;
    ok = 1'b0;
    while (line !== 1'b0 && n < limit) begin
      @(posedge clk);
      n++;
    end
    if (n < limit) begin
      repeat (BT / 2) @(posedge clk);
      ok = (line === 1'b0);
      for (int i = 0; i < 8; i++) begin
        repeat (BT) @(posedge clk);
        v[i] = line;
      end
      repeat (BT) @(posedge clk);
      ok = ok && (line === 1'b1);
    end
  endtask
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/10ps
module testbench;
  localparam int PM_BYTES = 16;
  localparam int LIMIT = 40000;
  logic sys_clk, rst_n, pin, pin_out, pin_oe, host_low, ok;
  dsp_pkg::dsp_rst_src_t rst_src;
  dsp_pkg::dsp_ctl_t ctl_wdata;
  logic stop_mode, small_package, read_protect, ctl_wr, dbg_on, brk_on, sys_rst, crc_busy;
  logic step_req, stuff_req, exec_valid, exec_ready;
  logic [7:0] stuff_op, exec_op, exec_data, pm_data, b;
  logic [2:0] exec_len;
  logic [dsp_pkg::PM_AW-1:0] pm_addr;
  logic [15:0] crc_e;
  logic [7:0] got[$];
  logic [7:0] ins[6] = '{8'h05, 8'hB1, 8'hC2, 8'hD3, 8'hE4, 8'h01};
  int err_total, check_count, cyc, steps, stuffs, rst_cnt, busy_cyc;
  // shared line: host pulls low, else the port or the pull-up
  assign pin = host_low ? 1'b0 : (pin_oe ? pin_out : 1'b1);
  dsp_top #(.PM_BYTES(PM_BYTES)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .debug_serial_pin_in(pin),
    .debug_serial_pin_out(pin_out), .debug_serial_pin_oe(pin_oe), .rst_src(rst_src), .stop_mode(stop_mode),
    .small_package(small_package), .read_protect(read_protect), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
    .debug_mode_enable(dbg_on), .breakpoint_instruction_en(brk_on), .sys_reset_req(sys_rst), .pm_addr(pm_addr),
    .pm_data(pm_data), .crc_busy(crc_busy), .step_req(step_req), .stuff_req(stuff_req), .stuff_opcode(stuff_op),
    .exec_opcode(exec_op), .exec_len(exec_len), .exec_valid(exec_valid), .exec_ready(exec_ready),
    .exec_data(exec_data));
  dsp_host #(.BT(16)) i_host (.clk(sys_clk), .line(pin), .host_low(host_low));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  function automatic logic [7:0] pm_byte(input logic [12:0] a);
    return a[7:0] * 8'h25 + 8'h11;
  endfunction
  // reference crc, msb first, all-ones start, no final inversion
  function automatic logic [15:0] crc_ref();
    logic [15:0] c;
    c = 16'hFFFF;
    for (int a = 0; a < PM_BYTES; a++) begin
      c = c ^ {pm_byte(a[12:0]), 8'h00};
      for (int k = 0; k < 8; k++) c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
    end
    return c;
  endfunction
  // registered memory: data for an address stands from the next rising edge
  always @(posedge sys_clk) pm_data <= pm_byte(pm_addr);
  // decoder length is the opcode's low bits, ready before the next edge
  always @(negedge sys_clk) exec_len <= exec_op[2:0];
  // event counters and the hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (step_req === 1'b1) steps++;
    if (stuff_req === 1'b1) stuffs++;
    if (sys_rst === 1'b1) rst_cnt++;
    if (crc_busy === 1'b1) busy_cyc++;
    if (exec_valid === 1'b1 && exec_ready === 1'b1) got.push_back(exec_data);
    if (cyc == LIMIT) begin
      err_total++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic get(input logic [7:0] e);
    i_host.recv_byte(2000, b, ok);
    chk_bit("reply framing", 1'b1, ok);
    chk_byte("reply byte", e, b);
    // let the stop bit finish before the host talks again
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic ctl(input logic m, input logic k, input logic r);
    @(negedge sys_clk);
    ctl_wr = 1'b1;
    ctl_wdata = {m, k, r};
    @(negedge sys_clk);
    ctl_wr = 1'b0;
    @(negedge sys_clk);
  endtask
  initial begin
    {rst_n, ctl_wr, stop_mode, small_package, read_protect, exec_ready} = '0;
    rst_src = '0;
    ctl_wdata = '0;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (40) @(negedge sys_clk);
    chk_bit("idle enable", 1'b0, pin_oe);
    i_host.send_byte(8'h80);
    chk_bit("large part stays out", 1'b0, dbg_on);
    i_host.send_byte(8'h0E);
    chk_bit("prompt reply", 1'b1, pin_oe);
    get(8'hFF);
    get(8'hFF);
    chk_bit("no scan outside debug", 1'b1, busy_cyc == 0);
    ctl(1'b1, 1'b1, 1'b0);
    chk_bit("debug on", 1'b1, dbg_on);
    chk_bit("break enabled", 1'b1, brk_on);
    crc_e = crc_ref();
    i_host.send_byte(8'h0E);
    get(crc_e[15:8]);
    get(crc_e[7:0]);
    chk_bit("scan length", 1'b1, busy_cyc >= PM_BYTES && busy_cyc <= PM_BYTES + 8);
    chk_bit("line released", 1'b0, pin_oe);
    i_host.send_byte(8'h10);
    chk_bit("one step", 1'b1, steps == 1);
    read_protect = 1'b1;
    i_host.send_byte(8'h10);
    i_host.send_byte(8'h11);
    i_host.send_byte(8'h5A);
    chk_bit("protected step ignored", 1'b1, steps == 1);
    chk_bit("protected stuff ignored", 1'b1, stuffs == 0);
    read_protect = 1'b0;
    i_host.send_byte(8'h11);
    i_host.send_byte(8'hA7);
    chk_bit("one stuff", 1'b1, stuffs == 1);
    chk_byte("stuff opcode", 8'hA7, stuff_op);
    ctl(1'b0, 1'b0, 1'b0);
    chk_bit("software exit", 1'b0, dbg_on);
    i_host.send_byte(8'h12);
    i_host.send_byte(8'h0E);
    chk_bit("swallowed byte not answered", 1'b0, pin_oe);
    ctl(1'b1, 1'b0, 1'b0);
    // five-byte instruction with the cpu stalled for two bytes, then a one-byte one
    i_host.send_byte(8'h12);
    for (int i = 0; i < 5; i++) begin
      i_host.send_byte(ins[i]);
      if (i == 1) exec_ready = 1'b1;
    end
    i_host.send_byte(8'h12);
    i_host.send_byte(ins[5]);
    i_host.send_byte(8'h10);
    repeat (4) @(negedge sys_clk);
    chk_bit("exec byte count", 1'b1, got.size() == 6);
    for (int i = 0; i < 6 && i < got.size(); i++) chk_byte("exec byte", ins[i], got[i]);
    chk_bit("step after exec", 1'b1, steps == 2);
    ctl(1'b1, 1'b0, 1'b1);
    chk_bit("one reset request", 1'b1, rst_cnt == 1);
    stop_mode = 1'b1;
    i_host.send_byte(8'h00);
    stop_mode = 1'b0;
    chk_bit("stop wake reset", 1'b1, rst_cnt > 10);
    for (int i = 0; i < 4; i++) begin
      ctl(1'b1, 1'b1, 1'b0);
      rst_src = dsp_pkg::dsp_rst_src_t'(4'h8 >> i);
      @(negedge sys_clk);
      rst_src = '0;
      chk_bit("source clears mode", 1'b0, dbg_on);
      chk_bit("source clears break", 1'b0, brk_on);
    end
    small_package = 1'b1;
    repeat (10) @(negedge sys_clk);
    i_host.send_byte(8'h80);
    chk_bit("small part enters debug", 1'b1, dbg_on);
    i_host.send_byte(8'h10);
    chk_bit("step after recalibration", 1'b1, steps == 3);
    close_out();
  end
endmodule
bind dsp_top dsp_chk #(.PM_BYTES(PM_BYTES)) i_chk (.sys_clk, .rst_n, .debug_serial_pin_in, .debug_serial_pin_out,
  .debug_serial_pin_oe, .rst_src, .stop_mode, .read_protect, .ctl_wr, .ctl_wdata, .debug_mode_enable,
  .breakpoint_instruction_en, .sys_reset_req, .crc_busy, .step_req, .stuff_req, .stuff_opcode, .exec_valid,
  .exec_ready, .exec_data);
